/* File: vbus_alarm_and_setpoint_regs.sv */
`include "vbus_alarm_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module vbus_alarm_and_setpoint_regs (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire vbus_alarm_pkg::reg_req_t    reg_req,
  output logic [7:0]                       reg_rdata,
  input  wire logic                        alarm_disable_bit,
  input  wire vbus_alarm_pkg::vout_meas_t  vout_meas,
  input  wire logic                        high_alarm_clear,
  input  wire logic                        low_alarm_clear,
  output logic                             high_voltage_alarm_flag,
  output logic                             low_voltage_alarm_flag,
  input  wire logic                        fine_resolution_select,
  input  wire logic                        nondefault_cmd,
  output logic                             slew_start,
  output vbus_alarm_pkg::slew_target_t     slew_target,
  output logic                             setpoint_in_range
);

  logic [9:0]                   high_trip_level_reg;
  logic [9:0]                   low_trip_level_reg;
  logic [15:0]                  output_setpoint_reg;
  logic [7:0]                   rdata_reg;
  logic                         high_flag_reg;
  logic                         low_flag_reg;
  logic                         slew_start_reg;
  vbus_alarm_pkg::slew_target_t slew_target_reg;

  wire wr_hi_l = reg_req.we && (reg_req.addr == `HIGH_TRIP_LEVEL_LOWER_OFS);
  wire wr_hi_h = reg_req.we && (reg_req.addr == `HIGH_TRIP_LEVEL_UPPER_OFS);
  wire wr_lo_l = reg_req.we && (reg_req.addr == `LOW_TRIP_LEVEL_LOWER_OFS);
  wire wr_lo_h = reg_req.we && (reg_req.addr == `LOW_TRIP_LEVEL_UPPER_OFS);
  wire wr_sp_l = reg_req.we && (reg_req.addr == `OUTPUT_SETPOINT_LOWER_OFS);
  wire wr_sp_h = reg_req.we && (reg_req.addr == `OUTPUT_SETPOINT_UPPER_OFS);

  // bits above the trip fields read as zero, unmapped reads give zero
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_req.addr)
      `HIGH_TRIP_LEVEL_LOWER_OFS: rd_mux = high_trip_level_reg[7:0];
      `HIGH_TRIP_LEVEL_UPPER_OFS: rd_mux = {6'h00, high_trip_level_reg[`TRIP_UPPER_MSB:`TRIP_UPPER_LSB]};
      `LOW_TRIP_LEVEL_LOWER_OFS:  rd_mux = low_trip_level_reg[7:0];
      `LOW_TRIP_LEVEL_UPPER_OFS:  rd_mux = {6'h00, low_trip_level_reg[`TRIP_UPPER_MSB:`TRIP_UPPER_LSB]};
      `OUTPUT_SETPOINT_LOWER_OFS: rd_mux = output_setpoint_reg[7:0];
      `OUTPUT_SETPOINT_UPPER_OFS: rd_mux = output_setpoint_reg[15:8];
      default:                    rd_mux = 8'h00;
    endcase
  end

  // comparisons only on the measurement's own done cycle
  wire alarms_on = !alarm_disable_bit;
  wire high_hit  = alarms_on && vout_meas.done && (vout_meas.level > high_trip_level_reg);
  wire low_hit   = alarms_on && vout_meas.done && (vout_meas.level < low_trip_level_reg);

  // set beats clear so an event in the clearing cycle is not lost
  wire high_flag_next = high_hit | (high_flag_reg & ~high_alarm_clear);
  wire low_flag_next  = low_hit | (low_flag_reg & ~low_alarm_clear);

  // target captured at command time; later writes do not move a slew in progress
  wire fine_sel = fine_resolution_select;
  wire [10:0] coarse_code = {1'b0, output_setpoint_reg[`COARSE_CODE_MSB:0]};
  wire [10:0] fine_code   = output_setpoint_reg[`FINE_CODE_MSB:0];
  wire [10:0] code_next   = fine_sel ? fine_code : coarse_code;

  // range flag is advisory only; the manager is trusted to write legal codes
  wire in_range = fine_sel ?
    (output_setpoint_reg >= `FINE_CODE_MIN) && (output_setpoint_reg <= `FINE_CODE_MAX) :
    (output_setpoint_reg >= `COARSE_CODE_MIN) && (output_setpoint_reg <= `COARSE_CODE_MAX);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      high_trip_level_reg <= `TRIP_LEVEL_RST;
      low_trip_level_reg  <= `TRIP_LEVEL_RST;
    end else begin
      if (wr_hi_l) begin
        high_trip_level_reg[7:0] <= reg_req.wdata;
      end
      if (wr_hi_h) begin
        high_trip_level_reg[`TRIP_UPPER_MSB:`TRIP_UPPER_LSB] <= reg_req.wdata[1:0];
      end
      if (wr_lo_l) begin
        low_trip_level_reg[7:0] <= reg_req.wdata;
      end
      if (wr_lo_h) begin
        low_trip_level_reg[`TRIP_UPPER_MSB:`TRIP_UPPER_LSB] <= reg_req.wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      output_setpoint_reg <= `OUTPUT_SETPOINT_RST;
    end else begin
      if (wr_sp_l) begin
        output_setpoint_reg[7:0] <= reg_req.wdata;
      end
      if (wr_sp_h) begin
        output_setpoint_reg[15:8] <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (reg_req.re) begin
      rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      high_flag_reg <= 1'b0;
      low_flag_reg  <= 1'b0;
    end else begin
      high_flag_reg <= high_flag_next;
      low_flag_reg  <= low_flag_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      slew_start_reg  <= 1'b0;
      slew_target_reg <= '0;
    end else begin
      slew_start_reg <= nondefault_cmd;
      if (nondefault_cmd) begin
        slew_target_reg.code <= code_next;
        slew_target_reg.fine <= fine_sel;
      end
    end
  end

  assign reg_rdata               = rdata_reg;
  assign high_voltage_alarm_flag = high_flag_reg;
  assign low_voltage_alarm_flag  = low_flag_reg;
  assign slew_start              = slew_start_reg;
  assign slew_target             = slew_target_reg;
  assign setpoint_in_range       = in_range;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  hi_trip_write_a: assert property (wr_hi_h |=> high_trip_level_reg[9:8] == $past(reg_req.wdata[1:0]))
    else $error("high trip upper bits not stored");
  lo_trip_read_a: assert property (reg_req.re && reg_req.addr == `LOW_TRIP_LEVEL_UPPER_OFS
      |=> reg_rdata == {6'h00, $past(low_trip_level_reg[9:8])})
    else $error("low trip upper readback wrong");
  alarm_disabled_a: assert property (alarm_disable_bit && !high_flag_reg |=> !high_flag_reg)
    else $error("high flag set while alarms disabled");
  low_alarm_set_a: assert property (vout_meas.done && !alarm_disable_bit
      && vout_meas.level < low_trip_level_reg |=> low_voltage_alarm_flag)
    else $error("low alarm not set");
  low_reassert_a: assert property (low_alarm_clear && low_hit |=> low_voltage_alarm_flag)
    else $error("low alarm lost on clear");
  setpoint_no_slew_a: assert property ((wr_sp_l || wr_sp_h) && !nondefault_cmd |=> !slew_start)
    else $error("slew started by a write");
  slew_load_a: assert property (nondefault_cmd |=> slew_start
      && slew_target.code == (slew_target.fine ? $past(output_setpoint_reg[10:0])
      : {1'b0, $past(output_setpoint_reg[9:0])}))
    else $error("slew target not loaded");
  coarse_code_a: assert property (nondefault_cmd && !fine_resolution_select |=> !slew_target.code[10])
    else $error("coarse code wider than 10 bits");
  high_alarm_set_a: assert property (vout_meas.done && !alarm_disable_bit
      && vout_meas.level > high_trip_level_reg |=> high_voltage_alarm_flag)
    else $error("high alarm not set");
  high_clear_a: assert property (high_alarm_clear && !high_hit |=> !high_voltage_alarm_flag)
    else $error("high alarm not cleared");
  no_meas_hold_a: assert property (!vout_meas.done && !low_alarm_clear && !low_flag_reg |=> !low_flag_reg)
    else $error("low alarm set without a measurement");

  cov_high_alarm: cover property (high_hit ##1 high_alarm_clear ##1 high_hit);
  cov_low_alarm: cover property (low_hit ##1 low_voltage_alarm_flag);
  cov_fine_slew: cover property (fine_resolution_select && nondefault_cmd ##1 slew_start);

endmodule : vbus_alarm_and_setpoint_regs

`default_nettype wire

/* File: vbus_alarm_regs.svh */
`ifndef VBUS_ALARM_REGS_SVH
`define VBUS_ALARM_REGS_SVH

`define HIGH_TRIP_LEVEL_LOWER_OFS  8'h76
`define HIGH_TRIP_LEVEL_UPPER_OFS  8'h77
`define LOW_TRIP_LEVEL_LOWER_OFS   8'h78
`define LOW_TRIP_LEVEL_UPPER_OFS   8'h79
`define OUTPUT_SETPOINT_LOWER_OFS  8'h7a
`define OUTPUT_SETPOINT_UPPER_OFS  8'h7b

`define TRIP_LEVEL_RST             10'h000
`define OUTPUT_SETPOINT_RST        16'h0000
`define TRIP_UPPER_LSB             8
`define TRIP_UPPER_MSB             9

`define COARSE_CODE_MSB            9
`define FINE_CODE_MSB              10
`define COARSE_CODE_MIN            16'h00a5
`define COARSE_CODE_MAX            16'h03ff
`define FINE_CODE_MIN              16'h014a
`define FINE_CODE_MAX              16'h07ff

`endif

/* File: vbus_alarm_pkg.sv */
package vbus_alarm_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_t;

  typedef struct packed {
    logic [9:0] level;
    logic       done;
  } vout_meas_t;

  typedef struct packed {
    logic        fine;
    logic [10:0] code;
  } slew_target_t;

endpackage : vbus_alarm_pkg

/* File: port_manager_model.sv */
`include "vbus_alarm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module port_manager_model;
  // integer math only, the manager has no float unit
  function automatic logic [15:0] fine_code(input int v);
    fine_code = 16'(v / 10 - (304 * v / 100000 - 10));
  endfunction : fine_code
  // codes are checked here only after the testbench has written them
  function automatic logic legal(input logic [15:0] c, input logic f);
    legal = f ? (c >= `FINE_CODE_MIN && c <= `FINE_CODE_MAX) : (c >= `COARSE_CODE_MIN && c <= `COARSE_CODE_MAX);
  endfunction : legal
endmodule : port_manager_model
`default_nettype wire

/* File: tb_vbus_alarm_and_setpoint_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_vbus_alarm_and_setpoint_regs;
  logic clk = 0, rstn = 0, alarm_disable_bit = 0, high_alarm_clear = 0;
  logic low_alarm_clear = 0, fine_resolution_select = 0, nondefault_cmd = 0;
  vbus_alarm_pkg::reg_req_t     reg_req = '0;
  vbus_alarm_pkg::vout_meas_t   vout_meas = '0;
  vbus_alarm_pkg::slew_target_t slew_target;
  logic [7:0]  reg_rdata;
  logic        high_voltage_alarm_flag, low_voltage_alarm_flag, slew_start, setpoint_in_range;
  logic [15:0] sp;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  vbus_alarm_and_setpoint_regs i_vbus_alarm_and_setpoint_regs (.clk, .rstn, .reg_req, .reg_rdata,
    .alarm_disable_bit, .vout_meas, .high_alarm_clear, .low_alarm_clear, .high_voltage_alarm_flag,
    .low_voltage_alarm_flag, .fine_resolution_select, .nondefault_cmd, .slew_start, .slew_target,
    .setpoint_in_range);
  port_manager_model i_port_manager_model ();
  always #2.5 clk = ~clk;
  // the sequence needs under a hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) reg_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) reg_req <= '0;
    #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  task automatic meas(input logic [9:0] l, input logic h, lo);
    @(posedge clk) vout_meas <= '{l, 1'b1};
    @(posedge clk) vout_meas <= '0;
    #1 chk("high flag", 16'(high_voltage_alarm_flag), 16'(h));
    chk("low flag", 16'(low_voltage_alarm_flag), 16'(lo));
  endtask : meas
  task automatic clr;
    @(posedge clk) {high_alarm_clear, low_alarm_clear} <= 2'b11;
    @(posedge clk) {high_alarm_clear, low_alarm_clear} <= 2'b00;
    #1 chk("flags cleared", 16'({high_voltage_alarm_flag, low_voltage_alarm_flag}), 16'h0000);
  endtask : clr
  task automatic slew(input logic f, input logic [10:0] code);
    @(posedge clk) {fine_resolution_select, nondefault_cmd} <= {f, 1'b1};
    @(posedge clk) nondefault_cmd <= 1'b0;
    #1 chk("slew_start", 16'(slew_start), 16'h0001);
    chk("slew_target", 16'(slew_target), {4'h0, f, code});
    @(posedge clk) #1 chk("slew_start end", 16'(slew_start), 16'h0000);
  endtask : slew
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 8'h76; a <= 8'h7b; a++) rd(8'(a), 8'h00);
    wr(8'h76, 8'h00);
    wr(8'h77, 8'hfd);
    rd(8'h77, 8'h01);
    wr(8'h78, 8'h0a);
    wr(8'h79, 8'hfc);
    rd(8'h79, 8'h00);
    rd(8'h78, 8'h0a);
    rd(8'h80, 8'h00);
    meas(10'h00a, 1'b0, 1'b0);
    meas(10'h009, 1'b0, 1'b1);
    clr();
    meas(10'h005, 1'b0, 1'b1);
    meas(10'h101, 1'b1, 1'b1);
    clr();
    meas(10'h100, 1'b0, 1'b0);
    meas(10'h3ff, 1'b1, 1'b0);
    clr();
    @(posedge clk) alarm_disable_bit <= 1'b1;
    meas(10'h000, 1'b0, 1'b0);
    meas(10'h3ff, 1'b0, 1'b0);
    @(posedge clk) alarm_disable_bit <= 1'b0;
    meas(10'h000, 1'b0, 1'b1);
    @(posedge clk) begin
      vout_meas       <= '{10'h000, 1'b1};
      low_alarm_clear <= 1'b1;
    end
    @(posedge clk) begin
      vout_meas       <= '0;
      low_alarm_clear <= 1'b0;
    end
    #1 chk("low flag on clear", 16'(low_voltage_alarm_flag), 16'h0001);
    sp = i_port_manager_model.fine_code(5000);
    wr(8'h7a, sp[7:0]);
    wr(8'h7b, sp[15:8]);
    #1 chk("slew on write", 16'(slew_start), 16'h0000);
    rd(8'h7a, sp[7:0]);
    slew(1'b1, sp[10:0]);
    chk("in range", 16'(setpoint_in_range), 16'(i_port_manager_model.legal(sp, 1'b1)));
    wr(8'h7a, 8'hff);
    wr(8'h7b, 8'h07);
    slew(1'b0, 11'h3ff);
    chk("coarse range", 16'(setpoint_in_range), 16'(i_port_manager_model.legal(16'h07ff, 1'b0)));
    slew(1'b1, 11'h7ff);
    complete_run();
  end
endmodule : tb_vbus_alarm_and_setpoint_regs
`default_nettype wire
